// [design/dre_pkg.sv]
// Purpose: Constants and types for the extended diagnostic record builder
// Assumes: Byte-wide record, 16 bytes, read over a plain register port
// Notes: Field positions and fixed codes live here only
`default_nettype none
package dre_pkg;
  localparam int REC_BYTES = 16;
  localparam int BASIC_BYTES = 4;
  localparam logic [3:0] BYTE_TYPE = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h5;
  localparam logic [3:0] BYTE_CHANS = 4'h6;
  localparam logic [3:0] BYTE_GRPERR = 4'h7;
  localparam logic [3:0] BYTE_LOST0 = 4'h8;
  localparam logic [3:0] BYTE_LOST3 = 4'hB;
  localparam logic [6:0] CHTYPE_DIGIN = 7'h70;
  localparam logic [6:0] CHTYPE_FUNC = 7'h76;
  localparam logic [7:0] DIAG_BITS_PER_CH = 8'h08;
  localparam logic [7:0] CHANS_ALARM = 8'h08;
  localparam logic [7:0] CHANS_COUNTER = 8'h04;
  localparam int ALARM_INPUTS = 8;
  localparam int COUNTERS = 4;
  localparam int GROUP_SIZE = 4;
  localparam int GROUPS = 4;
  // Lost-event bit positions within a counter byte
  localparam int CNT_GATE_OPEN = 0;
  localparam int CNT_GATE_CLOSE = 1;
  localparam int CNT_OVF = 2;
  localparam int CNT_CMP = 3;
  localparam int CNT_LATCH = 4;
  // Extra register offsets beyond the record itself
  localparam logic [4:0] REG_REC_BASE = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_MASK = 5'h11;
  localparam logic [4:0] REG_CTRL = 5'h12;
  localparam int CTRL_VARIANT = 0;
  localparam int CTRL_MORE = 1;
  localparam int ST_ALARM_LOST = 0;
  localparam int ST_CNT_LOST = 1;
  localparam int ST_GRPERR = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef enum logic [0:0] {
    DRE_VAR_ALARM = 1'b0,
    DRE_VAR_COUNTER = 1'b1
  } dre_variant_t;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [4:0] unused_pad;
  } dre_unused_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dre_bus_t;

  typedef struct packed {
    logic [COUNTERS-1:0] gate_open;
    logic [COUNTERS-1:0] gate_close;
    logic [COUNTERS-1:0] ovf;
    logic [COUNTERS-1:0] cmp;
    logic [COUNTERS-1:0] latch;
  } dre_cnt_ev_t;
endpackage : dre_pkg
`default_nettype wire

// [design/dre_top.sv]
// Purpose: Builds and serves the 16-byte extended diagnostic record
// Assumes: Event and error inputs are synchronous pulses/levels on ref_clk
// Notes: Lost-event flags are sticky until software writes one to status
//
// Operation
// (RULE1) Record is four basic bytes then twelve module bytes, sixteen total.
// (RULE2) Alarm variant reports channel type 70h in byte 4 bits 6..0.
// (RULE3) Counter variant reports channel type 76h in byte 4 bits 6..0.
// (RULE4) Byte 4 bit 7 set when more channel types are present.
// (RULE5) Byte 5 always reports 08h diagnostic bits per channel.
// (RULE6) Alarm variant reports 08h channels in byte 6.
// (RULE7) Counter variant reports 04h channels in byte 6.
// (RULE8) Alarm byte 7 bits 0..3 flag errors per group of four inputs.
// (RULE9) Alarm bytes 8..11 hold lost flags on even bits, odd bits zero.
// (RULE10) Counter byte 7 bits 0..3 flag errors of counters 0..3.
// (RULE11) Counter byte bit 2 flags lost overflow/underflow/end value event.
// (RULE12) Counter byte bit 3 flags lost comparison value event.
// (RULE13) Counter 3 bits 0,1 flag lost gate open/close; others reserved.
// (RULE14) Counter 3 bit 4 flags lost latch event; upper bits zero.
// (RULE15) Reserved and fixed-zero bits, bytes 12..15 included, read zero.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module dre_top #(
  parameter int ALARM_INPUTS = dre_pkg::ALARM_INPUTS,
  parameter int COUNTERS = dre_pkg::COUNTERS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic [31:0] basic_rec,
  input wire logic [ALARM_INPUTS-1:0] alarm_lost_ev,
  input wire logic [ALARM_INPUTS-1:0] alarm_err,
  input wire dre_pkg::dre_cnt_ev_t cnt_lost_ev,
  input wire logic [COUNTERS-1:0] cnt_err
);
  localparam int NGRP = ALARM_INPUTS / dre_pkg::GROUP_SIZE;
  localparam int LOST_SLOTS =
    (dre_pkg::BYTE_LOST3 - dre_pkg::BYTE_LOST0 + 1) * dre_pkg::GROUP_SIZE;

  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic [7:0] status_r;
  logic [ALARM_INPUTS-1:0] alarm_lost_r;
  dre_pkg::dre_cnt_ev_t cnt_lost_r;
  logic [7:0] reg_rdata_r;
  logic irq_r;
  logic [7:0] rec [dre_pkg::REC_BYTES];
  logic [NGRP-1:0] grp_err;
  logic clr_lost;
  logic wr_status;
  dre_pkg::dre_variant_t variant;
  logic [LOST_SLOTS-1:0] alarm_lost_wide;
  logic more_types;

  assign variant = dre_pkg::dre_variant_t'(ctrl_r[dre_pkg::CTRL_VARIANT]);
  assign more_types = ctrl_r[dre_pkg::CTRL_MORE];
  // Padding to the full slot count keeps absent inputs reading zero
  assign alarm_lost_wide = LOST_SLOTS'(alarm_lost_r);
  assign wr_status = reg_wr && (reg_addr == dre_pkg::REG_STATUS);
  // Writing one to any lost-event status bit also clears the record flags
  assign clr_lost = wr_status &&
    (reg_wdata[dre_pkg::ST_ALARM_LOST] || reg_wdata[dre_pkg::ST_CNT_LOST]);

  // Group errors: OR of each run of four consecutive inputs
  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : g_grp
      assign grp_err[g] = |alarm_err[g*dre_pkg::GROUP_SIZE +: dre_pkg::GROUP_SIZE]; // RULE8
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= dre_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == dre_pkg::REG_CTRL) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= dre_pkg::MASK_RST;
    end else if (reg_wr && reg_addr == dre_pkg::REG_MASK) begin
      mask_r <= reg_wdata;
    end
  end

  // Sticky lost flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_lost_r <= '0;
      cnt_lost_r <= '0;
    end else begin
      alarm_lost_r <= (clr_lost ? '0 : alarm_lost_r) | alarm_lost_ev; // RULE9
      cnt_lost_r <= (clr_lost ? '0 : cnt_lost_r) | cnt_lost_ev; // RULE11 RULE12 RULE13 RULE14
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(wr_status ? reg_wdata : 8'h00))
        | (8'(|alarm_lost_ev) << dre_pkg::ST_ALARM_LOST)
        | (8'(|cnt_lost_ev) << dre_pkg::ST_CNT_LOST)
        | (8'(|{alarm_err, cnt_err}) << dre_pkg::ST_GRPERR);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // Both layouts are built side by side; the control bit only picks one,
  // so a variant change never leaves stale bits of the other layout
  genvar b;
  generate
    for (b = 0; b < dre_pkg::REC_BYTES; b++) begin : g_byte
      localparam int SLOT = (b - int'(dre_pkg::BYTE_LOST0)) * dre_pkg::GROUP_SIZE;
      localparam int CNT = b - int'(dre_pkg::BYTE_LOST0);
      logic [7:0] alarm_byte;
      logic [7:0] cnt_byte;
      if (b < dre_pkg::BASIC_BYTES) begin : g_basic
        assign alarm_byte = basic_rec[b*8 +: 8]; // RULE1
        assign cnt_byte = basic_rec[b*8 +: 8]; // RULE1
      end else if (b == dre_pkg::BYTE_TYPE) begin : g_type
        assign alarm_byte = {more_types, dre_pkg::CHTYPE_DIGIN}; // RULE2 RULE4
        assign cnt_byte = {more_types, dre_pkg::CHTYPE_FUNC}; // RULE3 RULE4
      end else if (b == dre_pkg::BYTE_BITS) begin : g_bits
        assign alarm_byte = dre_pkg::DIAG_BITS_PER_CH; // RULE5
        assign cnt_byte = dre_pkg::DIAG_BITS_PER_CH; // RULE5
      end else if (b == dre_pkg::BYTE_CHANS) begin : g_chans
        assign alarm_byte = dre_pkg::CHANS_ALARM; // RULE6
        assign cnt_byte = dre_pkg::CHANS_COUNTER; // RULE7
      end else if (b == dre_pkg::BYTE_GRPERR) begin : g_err
        assign alarm_byte = 8'(grp_err); // RULE8
        assign cnt_byte = 8'(cnt_err); // RULE10
      end else if (b <= dre_pkg::BYTE_LOST3) begin : g_lost
        always_comb begin
          alarm_byte = 8'h00; // RULE9
          for (int j = 0; j < dre_pkg::GROUP_SIZE; j++) begin
            alarm_byte[2*j] = alarm_lost_wide[SLOT+j]; // RULE9
          end
        end
        if (CNT < COUNTERS) begin : g_cnt
          always_comb begin
            cnt_byte = 8'h00; // RULE15
            cnt_byte[dre_pkg::CNT_OVF] = cnt_lost_r.ovf[CNT]; // RULE11
            cnt_byte[dre_pkg::CNT_CMP] = cnt_lost_r.cmp[CNT]; // RULE12
            // Gate and latch flags exist for the last counter only
            if (CNT == COUNTERS - 1) begin
              cnt_byte[dre_pkg::CNT_GATE_OPEN] = cnt_lost_r.gate_open[CNT]; // RULE13
              cnt_byte[dre_pkg::CNT_GATE_CLOSE] = cnt_lost_r.gate_close[CNT]; // RULE13
              cnt_byte[dre_pkg::CNT_LATCH] = cnt_lost_r.latch[CNT]; // RULE14
            end
          end
        end else begin : g_cnt_none
          assign cnt_byte = 8'h00; // RULE15
        end
      end else begin : g_tail
        assign alarm_byte = 8'h00; // RULE15
        assign cnt_byte = 8'h00; // RULE15
      end
      assign rec[b] = (variant == dre_pkg::DRE_VAR_ALARM) ? alarm_byte : cnt_byte;
    end
  endgenerate

  // Read data registered: valid the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_addr < 5'(dre_pkg::REC_BYTES)) begin
      reg_rdata_r <= rec[reg_addr[3:0]]; // RULE1
    end else begin
      case (reg_addr)
        dre_pkg::REG_STATUS: begin
          reg_rdata_r <= status_r;
        end
        dre_pkg::REG_MASK: begin
          reg_rdata_r <= mask_r;
        end
        dre_pkg::REG_CTRL: begin
          reg_rdata_r <= ctrl_r;
        end
        default: begin
          // Unmapped reads give zero rather than alias the record
          reg_rdata_r <= 8'h00;
        end
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign irq = irq_r;
endmodule : dre_top
`default_nettype wire

// [verif/dre_asserts.sv]
// Purpose: Port checks for the record builder
// Assumes: One clock, async low reset
// Notes: Variant is not visible here, so type checks accept both
`default_nettype none
module dre_asserts #(
  parameter int ALARM_INPUTS = 8,
  parameter int COUNTERS = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic [31:0] basic_rec,
  input wire logic [ALARM_INPUTS-1:0] alarm_lost_ev,
  input wire logic [ALARM_INPUTS-1:0] alarm_err,
  input wire dre_pkg::dre_cnt_ev_t cnt_lost_ev,
  input wire logic [COUNTERS-1:0] cnt_err
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_basic; reg_rd && reg_addr < 5'h04 |=>
    reg_rdata == $past(basic_rec[8*reg_addr[1:0] +: 8]); endproperty
  a_basic: assert property (p_basic) else $error("basic byte wrong");
  property p_type; reg_rd && reg_addr == 5'h04 |=>
    reg_rdata[6:0] inside {7'h70, 7'h76}; endproperty
  a_type: assert property (p_type) else $error("channel type wrong");
  property p_bits; reg_rd && reg_addr == 5'h05 |=> reg_rdata == 8'h08; endproperty
  a_bits: assert property (p_bits) else $error("bits per channel wrong");
  property p_chans; reg_rd && reg_addr == 5'h06 |=> reg_rdata inside {8'h04, 8'h08}; endproperty
  a_chans: assert property (p_chans) else $error("channel count wrong");
  property p_grp; reg_rd && reg_addr == 5'h07 |=> reg_rdata[7:4] == 4'h0; endproperty
  a_grp: assert property (p_grp) else $error("group byte upper bits set");
  property p_lost; reg_rd && reg_addr[4:2] == 3'h2 |=>
    !reg_rdata[7] && !reg_rdata[5]; endproperty
  a_lost: assert property (p_lost) else $error("fixed lost bit set");
  property p_tail; reg_rd && reg_addr[4:2] == 3'h3 |=> reg_rdata == 8'h00; endproperty
  a_tail: assert property (p_tail) else $error("tail byte not zero");
endmodule : dre_asserts
bind dre_top dre_asserts #(.ALARM_INPUTS(ALARM_INPUTS), .COUNTERS(COUNTERS)) i_dre_asserts (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .basic_rec(basic_rec),
  .alarm_lost_ev(alarm_lost_ev), .alarm_err(alarm_err), .cnt_lost_ev(cnt_lost_ev),
  .cnt_err(cnt_err));
`default_nettype wire

// [verif/tb.sv]
// Purpose: Register-level test of the record builder
// Assumes: Flags sticky until a status write
// Notes: Only inputs 0..7 exist, so alarm-variant bytes 10 and 11 stay zero
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_b, reg_wr, reg_rd, irq, vc, more;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, alarm_lost_ev, alarm_err, al;
  logic [31:0] basic_rec;
  logic [3:0] cnt_err;
  dre_pkg::dre_cnt_ev_t cnt_lost_ev, cl;
  int n_errors, n_checks;
  dre_top i_dre_top (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .basic_rec(basic_rec), .alarm_lost_ev(alarm_lost_ev), .alarm_err(alarm_err),
    .cnt_lost_ev(cnt_lost_ev), .cnt_err(cnt_err));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s exp %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("byte %0h", a), reg_rdata, e);
  endtask : rd
  function automatic logic [7:0] expb(input int i);
    int k;
    logic [3:0] b;
    k = (i - 8) & 3;
    b = (k < 2) ? al[4*k +: 4] : 4'h0;
    if (i < 4) return basic_rec[8*i +: 8];
    if (i == 4) return {more, vc ? 7'h76 : 7'h70};
    if (i == 5) return 8'h08;
    if (i == 6) return vc ? 8'h04 : 8'h08;
    if (i == 7) return vc ? {4'h0, cnt_err} : {6'h00, |alarm_err[7:4], |alarm_err[3:0]};
    if (i > 11) return 8'h00;
    if (!vc) return {1'b0, b[3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]};
    return {3'h0, k == 3 && cl.latch[3], cl.cmp[k], cl.ovf[k], k == 3 && cl.gate_close[3],
      k == 3 && cl.gate_open[3]};
  endfunction : expb
  task automatic dump;
    for (int i = 0; i < 16; i++) rd(i[4:0], expb(i));
  endtask : dump
  task automatic print_verdict;
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, vc, more, al, cl} = '0;
    {alarm_lost_ev, alarm_err, cnt_lost_ev, cnt_err} = '0;
    basic_rec = 32'hA1B2C3D4;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(5'h12, 8'h00);
    rd(5'h11, 8'h00);
    wr(5'h11, 8'h01);
    rd(5'h11, 8'h01);
    dump();
    @(posedge ref_clk);
    alarm_err <= 8'h10;
    alarm_lost_ev <= 8'h81;
    al = 8'h81;
    @(posedge ref_clk);
    alarm_lost_ev <= 8'h00;
    dump();
    chk("irq", {7'h00, irq}, 8'h01);
    rd(5'h10, 8'h05);
    wr(5'h10, 8'h01);
    al = 8'h00;
    rd(5'h08, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(5'h10, 8'h04);
    wr(5'h05, 8'hFF);
    rd(5'h05, 8'h08);
    rd(5'h1F, 8'h00);
    wr(5'h12, 8'h03);
    {vc, more} = 2'b11;
    cnt_err <= 4'h5;
    cnt_lost_ev <= '1;
    cl = '1;
    @(posedge ref_clk);
    cnt_lost_ev <= '0;
    dump();
    rd(5'h10, 8'h06);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(5'h10, 8'h02);
    cl = '0;
    rd(5'h0B, 8'h00);
    rd(5'h10, 8'h04);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
